// File: rtl/cksw_top.v
// Purpose: System clock switch sequencer with reference clock output
// Assumes: APB slave, zero wait states; oscillator status synchronous to pclk
// Notes:   Clock levels are sampled, so outputs are pclk-quantised
//
// Summary of operation
// - Switching and fail monitor work only when the enable fuse is zero.
// - Switching off: new selection is still written but unused; current shows the fuse source.
// - Switching off: switch request ignores writes and reads zero.
// - Keys 78h, 9Ah to high byte, then next write sets new source.
// - Keys 46h, 57h to low byte, then next write may set request.
// - Request with equal current and new source is cleared and aborted.
// - A real switch clears the lock status and clock fail flag.
// - Start target; wait start-up timer for crystal, lock for PLL.
// - Count ten new-source cycles, then change the system clock.
// - On completion clear request and copy new into current source.
// - Old source turned off unless low RC is needed or secondary enabled.
// - Processor keeps running; the sequencer never stalls the bus.
// - Direct switch between primary PLL and fast RC PLL is refused.
// - Reference enable bit drives the divided clock onto the pin.
// - Source bit picks primary oscillator or current system clock.
// - Sleep bit keeps the reference running in sleep or stops it.
// - Sleep output needs sleep and source bits and primary mode.
// - A fixed half-rate system clock output is also provided.
// - Source fields use the eight-entry three-bit source code.
// - Monitor enabled and freeze set: switch requests are locked out.
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`include "cksw_consts.vh"

module cksw_top #(
    parameter DIV_W = 4,
    parameter CNT_W = 15
) (
    // Clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Fuses and oscillator status
    input  wire        switch_enable_fuse,
    input  wire [2:0]  initial_source_fuse,
    input  wire        pri_is_crystal,
    input  wire        osc_startup_done,
    input  wire        pll_lock_in,
    input  wire        new_clk_tick,
    input  wire        clk_fail_in,
    input  wire        low_rc_needed,
    input  wire        sleep_mode,
    input  wire        half_out_mode,
    // Sampled clock levels
    input  wire        pri_clk_level,
    input  wire        sys_clk_level,
    // Oscillator and clock outputs
    output reg  [4:0]  osc_run,
    output reg  [2:0]  sys_clk_sel,
    output reg         switch_busy,
    output wire        refclk_pin,
    output wire        sys_clock_half_out
);
    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_CHECK = 3'h1;
    localparam [2:0] ST_START = 3'h2;
    localparam [2:0] ST_WAIT  = 3'h3;
    localparam [2:0] ST_COUNT = 3'h4;
    localparam [2:0] ST_DONE  = 3'h5;

    reg        started;
    reg  [2:0] state;
    reg  [2:0] cur_src;
    reg  [2:0] new_src;
    reg  [2:0] tgt_src;
    reg  [3:0] settle;
    reg        req;
    reg        freeze;
    reg        fail;
    reg        lock;
    reg        drv;
    reg        sec_en;
    reg  [1:0] hi_key;
    reg  [1:0] lo_key;
    reg  [4:0] run_int;
    reg        ref_en;
    reg        ref_slp;
    reg        ref_sel;
    reg  [3:0] ref_div;
    reg  [31:0] rd_mux;

    // Source requirements per code
    function [4:0] need;
        input [2:0] s;
        begin
            case (s)
                `CKSW_SRC_FAST:     need = 5'h01;
                `CKSW_SRC_FAST_PLL: need = 5'h11;
                `CKSW_SRC_PRI:      need = 5'h02;
                `CKSW_SRC_PRI_PLL:  need = 5'h12;
                `CKSW_SRC_SEC:      need = 5'h04;
                `CKSW_SRC_LOW_RC:   need = 5'h08;
                `CKSW_SRC_LOW_FAST: need = 5'h01;
                default:            need = 5'h01;
            endcase
        end
    endfunction

    // Bus decode; a write lands at the access edge only
    wire sw_on   = ~switch_enable_fuse;
    wire setup   = psel & ~penable;
    wire wr      = psel & penable & pready & pwrite;
    wire hit_osc = (paddr == `CKSW_OFS_OSC);
    wire hit_ref = (paddr == `CKSW_OFS_REF);
    wire wr_osc  = wr & hit_osc;
    wire wr_ref  = wr & hit_ref;
    wire [7:0] wb1 = pwdata[15:8];
    wire [7:0] wb0 = pwdata[7:0];

    // Byte write counts only after its key pair; request needs enable and no freeze
    wire hi_apply = wr_osc & pstrb[1] & (hi_key == `CKSW_KEY_OPEN);
    wire lo_apply = wr_osc & pstrb[0] & (lo_key == `CKSW_KEY_OPEN);
    wire req_set  = lo_apply & wb0[`CKSW_B_REQ] & sw_on & ~freeze;

    // Redundant or forbidden switches
    wire same_src = (new_src == cur_src);
    wire pll_hop  = ((cur_src == `CKSW_SRC_PRI_PLL) & (new_src == `CKSW_SRC_FAST_PLL)) |
                    ((cur_src == `CKSW_SRC_FAST_PLL) & (new_src == `CKSW_SRC_PRI_PLL));
    wire sw_start = (state == ST_CHECK) & ~same_src & ~pll_hop;

    // Target readiness
    wire tgt_pri  = (tgt_src == `CKSW_SRC_PRI) | (tgt_src == `CKSW_SRC_PRI_PLL);
    wire tgt_pll  = (tgt_src == `CKSW_SRC_FAST_PLL) | (tgt_src == `CKSW_SRC_PRI_PLL);
    wire ost_ok   = ~tgt_pri | ~pri_is_crystal | osc_startup_done;
    wire lock_ok  = ~tgt_pll | pll_lock_in;

    // Sources kept alive beside the active one
    wire [4:0] keep = {1'b0, low_rc_needed, sec_en, 2'b00};

    // Reference output may run in sleep only on the primary
    wire ref_sleep_ok = ref_slp & ref_sel & (cur_src == `CKSW_SRC_PRI);
    wire ref_run      = ref_en & (~sleep_mode | ref_sleep_ok);
    wire pri_down     = sleep_mode & ~(ref_en & ref_sleep_ok);
    wire ref_base     = ref_sel ? pri_clk_level : sys_clk_level;

    // Unlock trackers for both bytes; any other write breaks a pair
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hi_key <= `CKSW_KEY_NONE;
            lo_key <= `CKSW_KEY_NONE;
        end else if (wr) begin
            if (wr_osc & pstrb[1] & (hi_key == `CKSW_KEY_NONE) & (wb1 == `CKSW_KEY_HI_A)) begin
                hi_key <= `CKSW_KEY_HALF;
            end else if (wr_osc & pstrb[1] & (hi_key == `CKSW_KEY_HALF) &
                         (wb1 == `CKSW_KEY_HI_B)) begin
                hi_key <= `CKSW_KEY_OPEN;
            end else begin
                hi_key <= `CKSW_KEY_NONE;
            end
            if (wr_osc & pstrb[0] & (lo_key == `CKSW_KEY_NONE) & (wb0 == `CKSW_KEY_LO_A)) begin
                lo_key <= `CKSW_KEY_HALF;
            end else if (wr_osc & pstrb[0] & (lo_key == `CKSW_KEY_HALF) &
                         (wb0 == `CKSW_KEY_LO_B)) begin
                lo_key <= `CKSW_KEY_OPEN;
            end else begin
                lo_key <= `CKSW_KEY_NONE;
            end
        end
    end

    // New source field; fuse value is caught after reset release
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            new_src <= `CKSW_SRC_FAST;
        end else if (!started) begin
            new_src <= initial_source_fuse;
        end else if (hi_apply) begin
            new_src <= wb1[2:0];
        end
    end

    // Plain low byte controls; freeze can only be set
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            freeze <= 1'b0;
            drv    <= 1'b0;
            sec_en <= 1'b0;
        end else if (lo_apply) begin
            freeze <= freeze | (wb0[`CKSW_B_FREEZE] & sw_on);
            drv    <= wb0[`CKSW_B_DRV];
            sec_en <= wb0[`CKSW_B_SEC_EN];
        end
    end

    // Fail flag: hardware set beats software or switch clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fail <= 1'b0;
        end else if (sw_on & clk_fail_in) begin
            fail <= 1'b1;
        end else if (sw_start | (lo_apply & ~wb0[`CKSW_B_FAIL])) begin
            fail <= 1'b0;
        end
    end

    // Lock status follows the running PLL, dropped at switch start
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock <= 1'b0;
        end else if (sw_start) begin
            lock <= 1'b0;
        end else begin
            lock <= pll_lock_in & run_int[`CKSW_RUN_PLL];
        end
    end

    // Switch sequencer; the bus is never held, so code keeps running
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            started <= 1'b0;
            state   <= ST_IDLE;
            cur_src <= `CKSW_SRC_FAST;
            tgt_src <= `CKSW_SRC_FAST;
            settle  <= 4'h0;
            req     <= 1'b0;
            run_int <= 5'h00;
        end else if (!started | !sw_on) begin
            started <= 1'b1;
            state   <= ST_IDLE;
            cur_src <= initial_source_fuse;
            req     <= 1'b0;
            run_int <= need(initial_source_fuse) | keep;
        end else begin
            case (state)
                ST_IDLE: begin
                    run_int <= need(cur_src) | keep;
                    if (req) begin
                        state <= ST_CHECK;
                    end
                end
                ST_CHECK: begin
                    tgt_src <= new_src;
                    if (same_src | pll_hop) begin
                        req   <= 1'b0;
                        state <= ST_IDLE;
                    end else begin
                        state <= ST_START;
                    end
                end
                ST_START: begin
                    run_int <= run_int | need(tgt_src) | keep;
                    state   <= ST_WAIT;
                end
                ST_WAIT: begin
                    settle <= 4'h0;
                    if (ost_ok & lock_ok) begin
                        state <= ST_COUNT;
                    end
                end
                ST_COUNT: begin
                    if (new_clk_tick) begin
                        if (settle == `CKSW_SETTLE - 4'h1) begin
                            state <= ST_DONE;
                        end else begin
                            settle <= settle + 4'h1;
                        end
                    end
                end
                ST_DONE: begin
                    cur_src <= tgt_src;
                    req     <= 1'b0;
                    run_int <= need(tgt_src) | keep;
                    state   <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
            if (req_set) begin
                req <= 1'b1;
            end
        end
    end

    // Registered oscillator enables and clock select
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_run     <= 5'h00;
            sys_clk_sel <= `CKSW_SRC_FAST;
            switch_busy <= 1'b0;
        end else begin
            osc_run     <= run_int & ~({4'h0, pri_down} << `CKSW_RUN_PRI);
            sys_clk_sel <= cur_src;
            switch_busy <= (state != ST_IDLE);
        end
    end

    // Reference control register, free to write
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_en  <= 1'b0;
            ref_slp <= 1'b0;
            ref_sel <= 1'b0;
            ref_div <= 4'h0;
        end else if (wr_ref & pstrb[1]) begin
            ref_en  <= pwdata[`CKSW_R_EN];
            ref_slp <= pwdata[`CKSW_R_SLP];
            ref_sel <= pwdata[`CKSW_R_SEL];
            ref_div <= pwdata[`CKSW_R_DIV_MSB:`CKSW_R_DIV_LSB];
        end
    end

    // Read word assembly; unused bits read zero
    always @* begin
        rd_mux = 32'h0000_0000;
        if (hit_osc) begin
            rd_mux[`CKSW_CUR_MSB:`CKSW_CUR_LSB] = cur_src;
            rd_mux[`CKSW_NEW_MSB:`CKSW_NEW_LSB] = new_src;
            rd_mux[`CKSW_B_FREEZE] = freeze;
            rd_mux[`CKSW_B_LOCK]   = lock;
            rd_mux[`CKSW_B_FAIL]   = fail;
            rd_mux[`CKSW_B_DRV]    = drv;
            rd_mux[`CKSW_B_SEC_EN] = sec_en;
            rd_mux[`CKSW_B_REQ]    = req & sw_on;
        end else if (hit_ref) begin
            rd_mux[`CKSW_R_EN]  = ref_en;
            rd_mux[`CKSW_R_SLP] = ref_slp;
            rd_mux[`CKSW_R_SEL] = ref_sel;
            rd_mux[`CKSW_R_DIV_MSB:`CKSW_R_DIV_LSB] = ref_div;
        end
    end

    // APB answer one cycle after setup; unmapped gives an error
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~hit_osc & ~hit_ref;
            if (setup & ~pwrite) begin
                prdata <= rd_mux;
            end
        end
    end

    // Programmable reference output
    cksw_refdiv #(.DIV_W (DIV_W), .CNT_W (CNT_W)) u_ref (
        .clk        (pclk),
        .rstn       (presetn),
        .base_level (ref_base),
        .div        (ref_div),
        .run        (ref_run),
        .clk_out    (refclk_pin)
    );

    // Fixed half-rate system clock output
    cksw_refdiv #(.DIV_W (DIV_W), .CNT_W (CNT_W)) u_half (
        .clk        (pclk),
        .rstn       (presetn),
        .base_level (sys_clk_level),
        .div        (4'h1),
        .run        (half_out_mode),
        .clk_out    (sys_clock_half_out)
    );
endmodule // cksw_top

// File: rtl/cksw_consts.vh
// Purpose: Shared constants of the clock switch and reference output block
// Assumes: Included by bare name from every design file of the block
// Notes:   Definitions only
`ifndef CKSW_CONSTS_VH
`define CKSW_CONSTS_VH

// Register byte addresses on APB
`define CKSW_OFS_OSC    12'h000
`define CKSW_OFS_REF    12'h004

// Two-write unlock keys per control byte
`define CKSW_KEY_HI_A   8'h78
`define CKSW_KEY_HI_B   8'h9a
`define CKSW_KEY_LO_A   8'h46
`define CKSW_KEY_LO_B   8'h57

// Unlock progress codes
`define CKSW_KEY_NONE   2'h0
`define CKSW_KEY_HALF   2'h1
`define CKSW_KEY_OPEN   2'h2

// Clock source codes
`define CKSW_SRC_FAST     3'h0
`define CKSW_SRC_FAST_PLL 3'h1
`define CKSW_SRC_PRI      3'h2
`define CKSW_SRC_PRI_PLL  3'h3
`define CKSW_SRC_SEC      3'h4
`define CKSW_SRC_LOW_RC   3'h5
`define CKSW_SRC_LOW_FAST 3'h6
`define CKSW_SRC_FAST_DIV 3'h7

// Oscillator control register fields
`define CKSW_B_REQ      0
`define CKSW_B_SEC_EN   1
`define CKSW_B_DRV      2
`define CKSW_B_FAIL     3
`define CKSW_B_LOCK     5
`define CKSW_B_FREEZE   7
`define CKSW_NEW_MSB    10
`define CKSW_NEW_LSB    8
`define CKSW_CUR_MSB    14
`define CKSW_CUR_LSB    12

// Reference control register fields
`define CKSW_R_EN       15
`define CKSW_R_SLP      13
`define CKSW_R_SEL      12
`define CKSW_R_DIV_MSB  11
`define CKSW_R_DIV_LSB  8

// Oscillator run vector bits
`define CKSW_RUN_FAST   0
`define CKSW_RUN_PRI    1
`define CKSW_RUN_SEC    2
`define CKSW_RUN_LOW    3
`define CKSW_RUN_PLL    4

// Cycles of the new source before changeover
`define CKSW_SETTLE     4'ha

`endif

// File: rtl/cksw_refdiv.v
// Purpose: Power-of-two divider of a sampled clock level
// Assumes: Base level is synchronous to clk and below half its rate
// Notes:   Field 0 passes the base level through one flop
`include "cksw_consts.vh"

module cksw_refdiv #(
    parameter DIV_W = 4,
    parameter CNT_W = 15
) (
    // Clock and reset
    input  wire             clk,
    input  wire             rstn,
    // Control
    input  wire             base_level,
    input  wire [DIV_W-1:0] div,
    input  wire             run,
    // Divided clock
    output reg              clk_out
);
    localparam [CNT_W-1:0] ONE   = 1;
    localparam [DIV_W-1:0] D_ONE = 1;

    reg              prev;
    reg  [CNT_W-1:0] cnt;
    wire             rise    = base_level & ~prev;
    // Half period in base edges, less one
    wire [CNT_W-1:0] half_m1 = (ONE << (div - D_ONE)) - ONE;

    // Edge detect and toggle counter; stopped output sits low
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prev    <= 1'b0;
            cnt     <= {CNT_W{1'b0}};
            clk_out <= 1'b0;
        end else begin
            prev <= base_level;
            if (!run) begin
                cnt     <= {CNT_W{1'b0}};
                clk_out <= 1'b0;
            end else if (div == {DIV_W{1'b0}}) begin
                clk_out <= base_level;
            end else if (rise) begin
                if (cnt == half_m1) begin
                    cnt     <= {CNT_W{1'b0}};
                    clk_out <= ~clk_out;
                end else begin
                    cnt <= cnt + ONE;
                end
            end
        end
    end
endmodule // cksw_refdiv

// File: tb/cksw_properties.sv
// Purpose: Port-level properties of the clock switch block
// Assumes: Bound to cksw_top, one pclk domain
// Notes:   Sees only the top-level ports
module cksw_checker #(
    parameter DIV_W = 4,
    parameter CNT_W = 15
) (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Control and outputs
    input wire logic        switch_enable_fuse,
    input wire logic        half_out_mode,
    input wire logic        switch_busy,
    input wire logic        sys_clock_half_out
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Bus phases
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence access_s;
        psel && penable && pready;
    endsequence
    // Only two word addresses decode
    wire mapped = (paddr == 12'h000) || (paddr == 12'h004);

    ready_after_setup_a: assert property (setup_s |=> access_s)
        else $error("no ready after setup");
    ready_one_cycle_a: assert property (pready |=> !pready)
        else $error("ready held too long");
    ready_in_access_a: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    err_unmapped_a: assert property (access_s |-> pslverr == !mapped)
        else $error("wrong error response");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    rd_hold_a: assert property (!$past(psel && !penable && !pwrite) |-> $stable(prdata))
        else $error("read data moved");
    rd_err_zero_a: assert property (psel && penable && pready && !pwrite && !mapped |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    busy_enabled_a: assert property ($rose(switch_busy) |-> !switch_enable_fuse)
        else $error("switch ran while disabled");
    half_off_a: assert property (!half_out_mode [*2] |-> !sys_clock_half_out)
        else $error("half output while off");
endmodule // cksw_checker

bind cksw_top cksw_checker #(.DIV_W(DIV_W), .CNT_W(CNT_W)) chk_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .switch_enable_fuse(switch_enable_fuse), .half_out_mode(half_out_mode),
    .switch_busy(switch_busy), .sys_clock_half_out(sys_clock_half_out)
);

// File: tb/cksw_tb.sv
// Purpose: Self-checking bench for the clock switch block
// Assumes: Zero-wait APB; sampled clock levels come from a free counter
// Notes:   Divider checks count rising edges in a 128-cycle window
`include "cksw_consts.vh"

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    // Bench-side drive and observe
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rdata;
    logic [3:0]  pstrb = 0;
    logic        pready, pslverr, err, ref_pin, half_pin, busy;
    logic        fuse_off = 1, osc_up = 0, pll_up = 0, tick = 0, slp = 0, half_en = 0;
    logic        pri_lvl = 0, sys_lvl = 0, fail_in = 0;
    logic [2:0]  ck = 0, run_sel;
    logic [4:0]  osc_run;
    int          errors = 0, total_checks = 0;

    cksw_top dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .switch_enable_fuse(fuse_off), .initial_source_fuse(3'h0),
        .pri_is_crystal(1'b1), .osc_startup_done(osc_up), .pll_lock_in(pll_up),
        .new_clk_tick(tick), .clk_fail_in(fail_in), .low_rc_needed(1'b0), .sleep_mode(slp),
        .half_out_mode(half_en), .pri_clk_level(pri_lvl), .sys_clk_level(sys_lvl),
        .osc_run(osc_run), .sys_clk_sel(run_sel), .switch_busy(busy),
        .refclk_pin(ref_pin), .sys_clock_half_out(half_pin)
    );

    always #2 pclk = ~pclk;
    // Primary level period 4 cycles, system level period 8
    always @(posedge pclk) begin
        ck <= ck + 3'h1;
        pri_lvl <= ck[1];
        sys_lvl <= ck[2];
    end

    task stop_test;
        if (errors == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task cyc(input int k);
        repeat (k) @(posedge pclk);
    endtask

    // One transfer; request held until ready is seen at an edge
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
             input logic [3:0] s);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            errors++;
            stop_test;
        end
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task set_new(input logic [2:0] s);
        apb(1, `CKSW_OFS_OSC, 32'h7800, 4'h2);
        apb(1, `CKSW_OFS_OSC, 32'h9a00, 4'h2);
        apb(1, `CKSW_OFS_OSC, {21'h0, s, 8'h0}, 4'h2);
    endtask

    // Request writes the fail bit as one, so the flag is left alone
    task req;
        apb(1, `CKSW_OFS_OSC, 32'h46, 4'h1);
        apb(1, `CKSW_OFS_OSC, 32'h57, 4'h1);
        apb(1, `CKSW_OFS_OSC, 32'h09, 4'h1);
    endtask

    task fail_pulse;
        fail_in <= 1'b1;
        cyc(1);
        fail_in <= 1'b0;
    endtask

    task ticks(input int k);
        repeat (k) begin
            tick <= 1'b1;
            @(posedge pclk);
            tick <= 1'b0;
            @(posedge pclk);
        end
    endtask

    // Bounded wait for the sequencer to go idle
    task wait_idle;
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 64) begin
            @(posedge pclk);
            n++;
        end
        if (busy !== 1'b0) begin
            errors++;
            stop_test;
        end
        cyc(3);
    endtask

    task rises(input bit h, input int exp);
        int r;
        logic p, v;
        r = 0;
        p = h ? half_pin : ref_pin;
        repeat (128) begin
            @(posedge pclk);
            v = h ? half_pin : ref_pin;
            if (p === 1'b0 && v === 1'b1)
                r++;
            p = v;
        end
        check(r, exp);
    endtask

    task t_regs;
        apb(0, `CKSW_OFS_OSC, 0, 0);
        check(rdata, 32'h0);
        apb(0, 12'h008, 0, 0);
        check({err, rdata[30:0]}, 32'h80000000);
        apb(1, `CKSW_OFS_REF, 32'hffff70ff, 4'hf);
        apb(0, `CKSW_OFS_REF, 0, 0);
        check(rdata, 32'h00003000);
    endtask

    // A write between the keys must spoil the unlock
    task t_locked;
        apb(1, `CKSW_OFS_OSC, 32'h7800, 4'h2);
        apb(1, `CKSW_OFS_REF, 32'h0, 4'h1);
        apb(1, `CKSW_OFS_OSC, 32'h9a00, 4'h2);
        apb(1, `CKSW_OFS_OSC, 32'h0500, 4'h2);
        apb(0, `CKSW_OFS_OSC, 0, 0);
        check(rdata[10:8], 32'h0);
    endtask

    task t_disabled;
        set_new(`CKSW_SRC_PRI);
        req;
        fail_pulse;
        cyc(6);
        apb(0, `CKSW_OFS_OSC, 0, 0);
        check(rdata[0], 32'h0);
        check(rdata[3], 32'h0);
        check(rdata[14:12], 32'h0);
        check(run_sel, 32'h0);
    endtask

    // Monitor sets the fail flag; an aborted switch must leave it set
    task t_redundant;
        fail_pulse;
        set_new(`CKSW_SRC_FAST);
        req;
        cyc(4);
        apb(0, `CKSW_OFS_OSC, 0, 0);
        check({busy, rdata[0], rdata[3]}, 32'h1);
    endtask

    task t_switch;
        set_new(`CKSW_SRC_PRI);
        req;
        cyc(8);
        apb(0, `CKSW_OFS_OSC, 0, 0);
        check({busy, osc_run[`CKSW_RUN_PRI], rdata[0], rdata[14:12]}, 32'h38);
        check(rdata[3], 32'h0);
        osc_up <= 1'b1;
        cyc(4);
        ticks(9);
        cyc(4);
        check(run_sel, 32'h0);
        ticks(1);
        wait_idle;
        apb(0, `CKSW_OFS_OSC, 0, 0);
        check({run_sel, rdata[14:12], rdata[0]}, 32'h24);
        check(osc_run[`CKSW_RUN_FAST], 32'h0);
        pll_up <= 1'b1;
        set_new(`CKSW_SRC_PRI_PLL);
        req;
        cyc(6);
        ticks(10);
        wait_idle;
        apb(0, `CKSW_OFS_OSC, 0, 0);
        check({run_sel, rdata[5]}, 32'h7);
        set_new(`CKSW_SRC_FAST_PLL);
        req;
        cyc(6);
        apb(0, `CKSW_OFS_OSC, 0, 0);
        check({run_sel, rdata[14:12], rdata[0]}, 32'h36);
    endtask

    // Freeze set through the low byte locks out a later valid request
    task t_freeze;
        apb(1, `CKSW_OFS_OSC, 32'h46, 4'h1);
        apb(1, `CKSW_OFS_OSC, 32'h57, 4'h1);
        apb(1, `CKSW_OFS_OSC, 32'h88, 4'h1);
        set_new(`CKSW_SRC_FAST);
        req;
        cyc(4);
        apb(0, `CKSW_OFS_OSC, 0, 0);
        check({busy, rdata[7], rdata[0]}, 32'h2);
    endtask

    // Divider steps only grow so no count overruns a new limit
    task t_refout;
        for (int d = 1; d <= 4; d++) begin
            apb(1, `CKSW_OFS_REF, {16'h0, 3'h4, d[0], d[3:0], 8'h0}, 4'h2);
            cyc(140);
            rises(0, (d[0] ? 16 : 8) >> (d - 1));
        end
        slp <= 1'b1;
        cyc(4);
        rises(0, 0);
        slp <= 1'b0;
        apb(1, `CKSW_OFS_REF, 32'h0, 4'h2);
        cyc(4);
        rises(0, 0);
        half_en <= 1'b1;
        cyc(8);
        rises(1, 8);
        half_en <= 1'b0;
    endtask

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs;
        t_locked;
        t_disabled;
        fuse_off <= 1'b0;
        @(posedge pclk);
        t_redundant;
        t_switch;
        t_freeze;
        t_refout;
        stop_test;
    end
endmodule // tb
